// *** logic/wit_pkg.sv ***
// shared constants and types for the write-only i2c target link
package wit_pkg;

  localparam int WIT_BYTE_W = 8;

  // target address layout: fixed upper bits, strap bits, direction
  localparam logic [4:0] WIT_ADDR_FIXED = 5'h0f;
  localparam logic       WIT_RW_WRITE   = 1'b0;
  localparam int         WIT_FIX_MSB    = 7;
  localparam int         WIT_FIX_LSB    = 3;
  localparam int         WIT_STRAP_MSB  = 2;
  localparam int         WIT_STRAP_LSB  = 1;
  localparam int         WIT_RW_POS     = 0;

  // bit counter positions within one byte frame, and the register pointer step
  localparam logic [3:0] WIT_LAST_BIT = 4'h7;
  localparam logic [3:0] WIT_ACK_SLOT = 4'h8;
  localparam logic [3:0] WIT_CNT_ZERO = 4'h0;
  localparam logic [7:0] WIT_PTR_STEP = 8'h01;

  // controller timing, quarter bit cell sized by the low period
  localparam int WIT_CLK_NS   = 8;
  localparam int WIT_T_LOW_NS = 1300;
  localparam int WIT_Q_CYC    =
    (WIT_T_LOW_NS / 2 + WIT_CLK_NS - 1) / WIT_CLK_NS;

  // how the address select pin is tied
  typedef enum logic [1:0] {
    WIT_TIE_GND = 2'h0,
    WIT_TIE_VCC = 2'h1,
    WIT_TIE_SCL = 2'h2,
    WIT_TIE_SDA = 2'h3
  } wit_strap_t;

  // target progress through a frame
  typedef enum logic [3:0] {
    WIT_PH_ADDR   = 4'h1,
    WIT_PH_REG    = 4'h2,
    WIT_PH_DATA   = 4'h4,
    WIT_PH_IGNORE = 4'h8
  } wit_phase_t;

  // controller sequencer
  typedef enum logic [3:0] {
    WIT_H_IDLE  = 4'h1,
    WIT_H_START = 4'h2,
    WIT_H_BIT   = 4'h4,
    WIT_H_STOP  = 4'h8
  } wit_hstate_t;

  // strap tie to the two variable address bits
  function automatic logic [1:0] wit_strap_bits(input wit_strap_t s);
    logic [1:0] b;
    b = 2'h0;
    case (s)
      WIT_TIE_GND: b = 2'h0;
      WIT_TIE_VCC: b = 2'h3;
      WIT_TIE_SCL: b = 2'h1;
      WIT_TIE_SDA: b = 2'h2;
      default:     b = 2'h0;
    endcase
    return b;
  endfunction

endpackage

// *** logic/wit_link.sv ***
// link interface joining controller and target over scl and sda
`timescale 1ns/1ps
interface wit_link;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open drain wire with pull-up: any enabled low driver wins
  assign sda = ~((host_sda_oe & ~host_sda_o) |
                 (dev_sda_oe & ~dev_sda_o));

  modport ctrl (output scl, output host_sda_o, output host_sda_oe,
                input sda);
  modport target (input scl, input sda, output dev_sda_o,
                  output dev_sda_oe);
endinterface

// *** logic/wit_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
module wit_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         reset_n,
  // levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// *** logic/wit_host.sv ***
// controller end: writes a register address and data bytes
`timescale 1ns/1ps
module wit_host #(
  parameter int Q_CYC = wit_pkg::WIT_Q_CYC
) (
  // system
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // link
  wit_link.ctrl           link,
  // transfer request
  input  wire logic       xfer_valid,
  input  wire logic [6:0] xfer_target,
  input  wire logic [7:0] xfer_reg,
  output logic            xfer_ready,
  // data bytes
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_last,
  output logic            byte_ready,
  // outcome
  output logic            done,
  output logic            nack
);
  import wit_pkg::*;

  localparam int QW = $clog2(Q_CYC);

  wit_hstate_t state, next_state;
  logic [QW-1:0] qcnt, next_qcnt;
  logic [1:0] q, next_q;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic is_addr, next_is_addr, last_sent, next_last_sent;
  logic ack_ok, next_ack_ok, scl, next_scl, oe, next_oe;
  logic next_xfer_ready, next_byte_ready, next_done, next_nack;
  logic sda_s, tick;

  wit_sync #(.W(1), .RST_VAL(1'b1)) u_sda (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .d       (link.sda),
    .q       (sda_s)
  );

  assign tick = (qcnt == QW'(Q_CYC - 1));

  // sequencer: four quarters per bit cell
  always_comb begin
    next_state = state; next_qcnt = qcnt; next_q = q;
    next_bitn = bitn; next_sh = sh; next_is_addr = is_addr;
    next_last_sent = last_sent; next_ack_ok = ack_ok;
    next_scl = scl; next_oe = oe; next_xfer_ready = xfer_ready;
    next_byte_ready = 1'b0; next_done = 1'b0; next_nack = 1'b0;
    if (clk_en) begin
      next_qcnt = tick ? '0 : qcnt + QW'(1);
      case (state)
        WIT_H_IDLE: begin
          next_xfer_ready = 1'b1;
          next_qcnt = '0;
          if (xfer_valid && xfer_ready) begin
            next_xfer_ready = 1'b0;
            next_sh = {xfer_target, WIT_RW_WRITE};
            next_is_addr = 1'b1;
            next_last_sent = 1'b0;
            next_q = 2'h0;
            next_state = WIT_H_START;
          end
        end
        WIT_H_START: if (tick) begin
          if (q == 2'h0) begin
            next_oe = 1'b1;
            next_q = 2'h1;
          end else begin
            next_scl = 1'b0;
            next_q = 2'h0;
            next_bitn = WIT_CNT_ZERO;
            next_state = WIT_H_BIT;
          end
        end
        WIT_H_BIT: if (tick) begin
          case (q)
            2'h0: begin
              // data changes only while scl is low
              next_oe = (bitn != WIT_ACK_SLOT) && !sh[7];
              next_q = 2'h1;
            end
            2'h1: begin
              next_scl = 1'b1;
              next_q = 2'h2;
            end
            2'h2: begin
              if (bitn == WIT_ACK_SLOT) next_ack_ok = !sda_s;
              next_q = 2'h3;
            end
            default: begin
              next_scl = 1'b0;
              if (bitn != WIT_ACK_SLOT) begin
                next_sh = {sh[6:0], 1'b0};
                next_bitn = bitn + 4'h1;
                next_q = 2'h0;
              end else if (!ack_ok) begin
                next_nack = 1'b1;
                next_q = 2'h0;
                next_state = WIT_H_STOP;
              end else if (is_addr) begin
                next_sh = xfer_reg;
                next_is_addr = 1'b0;
                next_bitn = WIT_CNT_ZERO;
                next_q = 2'h0;
              end else if (last_sent) begin
                next_q = 2'h0;
                next_state = WIT_H_STOP;
              end else if (byte_valid) begin
                // without a byte the clock is held low
                next_sh = byte_data;
                next_last_sent = byte_last;
                next_byte_ready = 1'b1;
                next_bitn = WIT_CNT_ZERO;
                next_q = 2'h0;
              end
            end
          endcase
        end
        WIT_H_STOP: if (tick) begin
          case (q)
            2'h0: begin
              next_oe = 1'b1;
              next_q = 2'h1;
            end
            2'h1: begin
              next_scl = 1'b1;
              next_q = 2'h2;
            end
            2'h2: begin
              next_oe = 1'b0;
              next_bitn = WIT_CNT_ZERO;
              next_q = 2'h3;
            end
            default: begin
              // two quarters of bus free time before the next start
              if (bitn == WIT_CNT_ZERO) begin
                next_bitn = 4'h1;
              end else begin
                next_done = ack_ok;
                next_state = WIT_H_IDLE;
              end
            end
          endcase
        end
        default: next_state = WIT_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= WIT_H_IDLE; qcnt <= '0; q <= 2'h0;
      bitn <= WIT_CNT_ZERO; sh <= 8'h00; is_addr <= 1'b0;
      last_sent <= 1'b0; ack_ok <= 1'b0; scl <= 1'b1; oe <= 1'b0;
      xfer_ready <= 1'b0; byte_ready <= 1'b0;
      done <= 1'b0; nack <= 1'b0;
    end else begin
      state <= next_state; qcnt <= next_qcnt; q <= next_q;
      bitn <= next_bitn; sh <= next_sh; is_addr <= next_is_addr;
      last_sent <= next_last_sent; ack_ok <= next_ack_ok;
      scl <= next_scl; oe <= next_oe; xfer_ready <= next_xfer_ready;
      byte_ready <= next_byte_ready;
      done <= next_done; nack <= next_nack;
    end
  end

  // cell of four quarters keeps scl under the rate ceiling
  assign link.scl = scl;
  assign link.host_sda_oe = oe;
  assign link.host_sda_o = 1'b0;
endmodule

// *** logic/wit_target.sv ***
// target end: write-only i2c port feeding register write strobes
`timescale 1ns/1ps
module wit_target (
  // system side
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  // address select tie
  input  wire wit_pkg::wit_strap_t strap_sel,
  // link
  wit_link.target                  link,
  // register file side
  output logic                     wr_en,
  output logic [7:0]               wr_addr,
  output logic [7:0]               wr_data,
  output logic                     frame_busy
);
  import wit_pkg::*;

  // reference domain state
  logic       sda_prev, next_sda_prev;
  logic       bus_idle, next_bus_idle;
  logic       link_hold, next_link_hold;
  logic       tgl_seen, next_tgl_seen;
  logic [1:0] strapped_address_bits, next_strapped_address_bits;
  logic [1:0] strap_s;
  logic       next_wr_en, next_frame_busy;
  logic [7:0] next_wr_addr, next_wr_data;
  logic [2:0] ref_s;
  logic       scl_s, sda_s, tgl_s, start_det, stop_det;

  // link domain state
  logic       link_rst_n;
  logic [2:0] lk_s;
  logic [1:0] lk_strap;
  logic       lk_en;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  wit_phase_t phase, next_phase;
  logic [7:0] ptr, next_ptr;
  logic       ack_want, next_ack_want;
  logic       emit;
  logic [7:0] byte_now;
  logic       addr_hit;
  logic       wr_tgl, next_wr_tgl;
  logic [7:0] ptr_hold, next_ptr_hold;
  logic [7:0] data_hold, next_data_hold;
  logic       ack_oe, next_ack_oe;

  // address select tie is a pin, so it is synchronised as well
  wit_sync #(.W(2), .RST_VAL(2'h0)) u_strap_sync (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .d       (strap_sel),
    .q       (strap_s)
  );

  // bus levels and write toggle into the reference domain
  wit_sync #(.W(3), .RST_VAL(3'h6)) u_ref_sync (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .d       ({link.scl, link.sda, wr_tgl}),
    .q       (ref_s)
  );
  assign scl_s = ref_s[2];
  assign sda_s = ref_s[1];
  assign tgl_s = ref_s[0];

  // enable resets high so the first frame is not frozen
  wit_sync #(.W(3), .RST_VAL(3'h1)) u_lk_sync (
    .clk     (link.scl),
    .reset_n (reset_n),
    .d       ({strapped_address_bits, clk_en}),
    .q       (lk_s)
  );
  assign lk_strap = lk_s[2:1];
  assign lk_en = lk_s[0];

  // sda edges with scl high mark start and stop
  assign start_det = scl_s && sda_prev && !sda_s;
  assign stop_det = scl_s && !sda_prev && sda_s;

  // frame tracking, strap capture and write strobe
  always_comb begin
    next_sda_prev = sda_prev;
    next_bus_idle = bus_idle;
    next_link_hold = link_hold;
    next_tgl_seen = tgl_seen;
    next_strapped_address_bits = strapped_address_bits;
    next_wr_en = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_frame_busy = frame_busy;
    if (clk_en) begin
      next_sda_prev = sda_s;
      if (stop_det) next_bus_idle = 1'b1;
      if (start_det) next_bus_idle = 1'b0;
      // a repeated start also pulses the hold for one cycle
      next_link_hold = start_det || next_bus_idle;
      next_frame_busy = !next_bus_idle;
      // a static tie, so following it every cycle is safe
      next_strapped_address_bits =
        wit_strap_bits(wit_strap_t'(strap_s));
      // hold registers are stable for a whole byte after the toggle
      next_tgl_seen = tgl_s;
      if (tgl_s != tgl_seen) begin
        next_wr_en = 1'b1;
        next_wr_addr = ptr_hold;
        next_wr_data = data_hold;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_prev <= 1'b1;
      bus_idle <= 1'b1;
      link_hold <= 1'b1;
      tgl_seen <= 1'b0;
      strapped_address_bits <= 2'h0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      frame_busy <= 1'b0;
    end else begin
      sda_prev <= next_sda_prev;
      bus_idle <= next_bus_idle;
      link_hold <= next_link_hold;
      tgl_seen <= next_tgl_seen;
      strapped_address_bits <= next_strapped_address_bits;
      wr_en <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      frame_busy <= next_frame_busy;
    end
  end

  // link logic is held clear outside frames and at each start
  assign link_rst_n = reset_n && !link_hold;

  assign byte_now = {sh[6:0], link.sda};
  assign addr_hit =
    (byte_now[WIT_FIX_MSB:WIT_FIX_LSB] == WIT_ADDR_FIXED) &&
    (byte_now[WIT_STRAP_MSB:WIT_STRAP_LSB] == lk_strap) &&
    (byte_now[WIT_RW_POS] == WIT_RW_WRITE);

  // bit shifter, sampled on the rising scl edge
  always_comb begin
    next_cnt = cnt;
    next_sh = sh;
    next_phase = phase;
    next_ptr = ptr;
    next_ack_want = ack_want;
    emit = 1'b0;
    if (lk_en) begin
      if (cnt == WIT_ACK_SLOT) begin
        next_cnt = WIT_CNT_ZERO;
        next_ack_want = 1'b0;
        case (phase)
          WIT_PH_ADDR: next_phase = WIT_PH_REG;
          WIT_PH_REG:  next_phase = WIT_PH_DATA;
          WIT_PH_DATA: next_ptr = ptr + WIT_PTR_STEP;
          default:     next_phase = phase;
        endcase
      end else begin
        next_sh = byte_now;
        next_cnt = cnt + 4'h1;
        if (cnt == WIT_LAST_BIT) begin
          case (phase)
            WIT_PH_ADDR: begin
              next_ack_want = addr_hit;
              // a miss or a read parks the port until a start
              if (!addr_hit) next_phase = WIT_PH_IGNORE;
            end
            WIT_PH_REG: begin
              next_ack_want = 1'b1;
              next_ptr = byte_now;
            end
            WIT_PH_DATA: begin
              next_ack_want = 1'b1;
              emit = 1'b1;
            end
            default: next_ack_want = 1'b0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge link.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt <= WIT_CNT_ZERO;
      sh <= 8'h00;
      phase <= WIT_PH_ADDR;
      ptr <= 8'h00;
      ack_want <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sh <= next_sh;
      phase <= next_phase;
      ptr <= next_ptr;
      ack_want <= next_ack_want;
    end
  end

  // write hand-off; kept out of the frame hold so stop cannot toggle
  always_comb begin
    next_wr_tgl = wr_tgl;
    next_ptr_hold = ptr_hold;
    next_data_hold = data_hold;
    if (emit) begin
      next_wr_tgl = !wr_tgl;
      next_ptr_hold = ptr;
      next_data_hold = byte_now;
    end
  end

  always_ff @(posedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      wr_tgl <= 1'b0;
      ptr_hold <= 8'h00;
      data_hold <= 8'h00;
    end else begin
      wr_tgl <= next_wr_tgl;
      ptr_hold <= next_ptr_hold;
      data_hold <= next_data_hold;
    end
  end

  // acknowledge driven from falling edge to falling edge
  always_comb begin
    next_ack_oe = ack_oe;
    if (lk_en) next_ack_oe = ack_want && (cnt == WIT_ACK_SLOT);
  end

  always_ff @(negedge link.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_oe <= 1'b0;
    end else begin
      ack_oe <= next_ack_oe;
    end
  end

  assign link.dev_sda_oe = ack_oe;
  assign link.dev_sda_o = 1'b0;
endmodule

// *** test/wit_link_monitor.sv ***
// concurrent checks on the shared scl and sda wires
`timescale 1ns/1ps
module wit_link_monitor #(
  parameter int Q_CYC = 8
) (
  // system
  input wire logic ref_clk,
  input wire logic reset_n,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  localparam int LIM = 6 * Q_CYC;
  // one scl period at the 2.5 us ceiling in 8 ns cycles, less one
  localparam int MIN_GAP = 312;
  logic [9:0] per_cnt;
  logic [9:0] next_per_cnt;
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic       next_in_frame;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       start_ev;
  logic       stop_ev;
  logic       rise_ev;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // wire events against the previous sample
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign rise_ev  = scl && !scl_q;

  // frame and bit slot tracking; count wraps after the ack slot
  always_comb begin
    next_in_frame = in_frame;
    next_cnt      = cnt;
    // saturates so the first rise after a long idle never trips
    next_per_cnt  = rise_ev ? 10'h000 :
                    (&per_cnt) ? per_cnt : per_cnt + 10'h001;
    if (start_ev) begin
      next_in_frame = 1'b1;
      next_cnt      = 4'h0;
    end else begin
      if (stop_ev) next_in_frame = 1'b0;
      if (rise_ev) next_cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
  end

  // idle bus is high on both wires, so reset there
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_frame <= 1'b0;
      cnt      <= 4'h0;
      per_cnt  <= 10'h3ff;
    end else begin
      scl_q    <= scl;
      sda_q    <= sda;
      in_frame <= next_in_frame;
      cnt      <= next_cnt;
      per_cnt  <= next_per_cnt;
    end
  end

  // ack steps: rise at scl fall, held, then seen high
  sequence s_ack_rise;
    $rose(dev_sda_oe);
  endsequence
  sequence s_held;
    dev_sda_oe[*8];
  endsequence
  property p_ack_stands;
    s_ack_rise |-> s_held ##[1:LIM] (scl && dev_sda_oe);
  endproperty

  a_ack_stands: assert property (p_ack_stands)
    else $error("ack not held into the ninth pulse");
  a_ack_after_eight: assert property (s_ack_rise |-> cnt == 4'h8)
    else $error("ack raised before eight bits");
  a_ack_ninth_bit: assert property (
    rise_ev && dev_sda_oe |-> cnt == 4'h8)
    else $error("ack driven outside the ninth slot");
  a_ack_on_fall: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target changed sda while scl high");
  a_ack_release: assert property (
    $fell(dev_sda_oe) |-> !scl && cnt == 4'h0)
    else $error("ack released at wrong moment");
  a_ack_in_frame: assert property (
    dev_sda_oe |-> in_frame && !dev_sda_o)
    else $error("target drove sda outside a frame");
  a_stop_frames: assert property (
    stop_ev |-> cnt == 4'h1 && !dev_sda_oe)
    else $error("stop not on a byte boundary");
  a_idle_sda_high: assert property (
    !in_frame && !start_ev |-> sda && !(host_sda_oe && host_sda_o))
    else $error("sda low while bus idle");
  a_scl_high_min: assert property (rise_ev |-> scl[*8])
    else $error("scl high phase too short");
  a_scl_rate: assert property (rise_ev |-> per_cnt >= MIN_GAP)
    else $error("scl period shorter than the rate ceiling");
endmodule

// *** test/write_only_i2c_target_port_test.sv ***
// self-checking bench joining controller and target ends
`timescale 1ns/1ps
module write_only_i2c_target_port_test;
  import wit_pkg::*;
  // full quarter length keeps scl under the rate ceiling on the wires
  localparam int Q = WIT_Q_CYC;
  logic        ref_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic        clk_en      = 1'b1;
  wit_strap_t  strap_sel   = WIT_TIE_GND;
  logic        xfer_valid  = 1'b0;
  logic [6:0]  xfer_target = 7'h00;
  logic [7:0]  xfer_reg    = 8'h00;
  logic        byte_valid  = 1'b0;
  logic [7:0]  byte_data   = 8'h00;
  logic        byte_last   = 1'b0;
  logic        xfer_ready;
  logic        byte_ready;
  logic        done;
  logic        nack;
  logic        wr_en;
  logic        frame_busy;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  int          fails       = 0;
  int          n_checks    = 0;
  logic [31:0] seed        = 32'h00013d6e;
  logic [15:0] exp_q[$];
  logic [1:0]  sb[4]       = '{2'h0, 2'h3, 2'h1, 2'h2};

  // free-running system clock
  always #4 ref_clk = ~ref_clk;

  wit_link link();
  wit_host #(.Q_CYC(Q)) i_wit_host (.ref_clk(ref_clk), .reset_n(reset_n),
    .clk_en(clk_en), .link(link), .xfer_valid(xfer_valid),
    .xfer_target(xfer_target), .xfer_reg(xfer_reg),
    .xfer_ready(xfer_ready), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_last(byte_last),
    .byte_ready(byte_ready), .done(done), .nack(nack));
  wit_target i_wit_target (.ref_clk(ref_clk), .reset_n(reset_n),
    .clk_en(clk_en), .strap_sel(strap_sel), .link(link), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .frame_busy(frame_busy));
  wit_link_monitor #(.Q_CYC(Q)) i_wit_link_monitor (.ref_clk(ref_clk),
    .reset_n(reset_n), .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one write frame; entered and left at a falling edge
  task automatic send(input logic [6:0] tgt, input logic [7:0] rg,
                      input int n, input logic ack);
    logic [7:0] d[4];
    int         k;
    k = 0;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      d[i] = seed[7:0];
      if (ack) exp_q.push_back({rg + 8'(i), d[i]});
    end
    xfer_target = tgt;
    xfer_reg    = rg;
    byte_data   = d[0];
    byte_last   = (n == 1);
    byte_valid  = 1'b1;
    xfer_valid  = 1'b1;
    for (int t = 0; t < 50 && xfer_ready !== 1'b1; t++) @(negedge ref_clk);
    @(negedge ref_clk);
    xfer_valid = 1'b0;
    // next byte offered only once the previous one was taken
    for (int t = 0; t < 300 * Q && done !== 1'b1 && nack !== 1'b1;
         t++) begin
      @(negedge ref_clk);
      if (byte_ready === 1'b1) begin
        check({15'h0, frame_busy}, 16'h0001);
        k++;
        if (k < n) begin
          byte_data = d[k];
          byte_last = (k == n - 1);
        end else byte_valid = 1'b0;
      end
    end
    byte_valid = 1'b0;
    check({15'h0, nack}, {15'h0, !ack});
    check({15'h0, done}, {15'h0, ack});
    check(16'(exp_q.size()), 16'h0000);
    // after a missing ack the stop is still on its way
    for (int t = 0; t < 8 * Q && xfer_ready !== 1'b1; t++)
      @(negedge ref_clk);
    check({15'h0, xfer_ready}, 16'h0001);
    check({15'h0, frame_busy}, 16'h0000);
    repeat (2 * Q) @(negedge ref_clk);
  endtask

  // each write strobe is matched against the oldest note
  always @(negedge ref_clk) begin
    if (wr_en === 1'b1) begin
      if (exp_q.size() == 0) check({wr_addr, wr_data}, 16'hdead);
      else check({wr_addr, wr_data}, exp_q.pop_front());
    end
  end

  // hang guard, about a quarter beyond four straps of frames
  initial begin
    #720000;
    fails++;
    final_report();
  end

  // strap is followed every cycle, yet each tie still gets its own reset
  initial begin
    for (int s = 0; s < 4; s++) begin
      strap_sel = wit_strap_t'(s);
      reset_n   = 1'b0;
      repeat (s == 0 ? 16 : 4) @(negedge ref_clk);
      check({wr_addr, wr_data}, 16'h0000);
      reset_n = 1'b1;
      repeat (8) @(negedge ref_clk);
      if (s[0]) send({WIT_ADDR_FIXED, ~sb[s]}, 8'h10, 1, 1'b0);
      else send({5'h0e, sb[s]}, 8'h10, 1, 1'b0);
      send({WIT_ADDR_FIXED, sb[s]}, 8'hfd + 8'(s), s + 1, 1'b1);
    end
    final_report();
  end
endmodule
